// file: src/blit_pattern_stroke_engine.sv
`timescale 1ns/1ps
module blit_pattern_stroke_engine
    import blit_engine_pkg::*;
#(
    parameter int PIX_W = 32
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic busy_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_x_o,
    output logic [15:0] mem_y_o,
    output logic [PIX_W-1:0] mem_wdata_o,
    output logic [31:0] mem_plane_mask_o,
    input wire logic mem_ack_i,
    input wire logic [PIX_W-1:0] mem_rdata_i
);
    if (PIX_W < 1 || PIX_W > 32)
    begin : g_check
        $error("PIX_W must lie between 1 and 32");
    end

    typedef struct packed {
        engine_state_t st;
        logic [15:0] cmd;
        logic [15:0] cur_x;
        logic [15:0] cur_y;
        logic [15:0] stp_x;
        logic [15:0] stp_y;
        logic [15:0] size_w;
        logic [15:0] size_h;
        logic [15:0] fmix;
        logic [15:0] bmix;
        logic [15:0] pctl;
        logic [31:0] fcol;
        logic [31:0] bcol;
        logic [31:0] wmask;
        logic [31:0] rmask;
        logic [15:0] vec;
        logic vec_full;
        logic op_vec;
        logic vec_hi;
        logic [3:0] vcnt;
        logic [15:0] sx;
        logic [15:0] sy;
        logic [15:0] dx;
        logic [15:0] dy;
        logic [15:0] xcnt;
        logic [15:0] ycnt;
        logic [PIX_W-1:0] src;
        logic [PIX_W-1:0] dst;
        logic req;
        logic we;
        logic [15:0] ax;
        logic [15:0] ay;
        logic [PIX_W-1:0] wdata;
        logic [31:0] rdata;
    } engine_regs_t;

    engine_regs_t r;
    engine_regs_t next_r;
    logic rst_meta;
    logic rst_sync;
    logic read_bit;
    logic sel_fore;
    logic need_src;
    logic [15:0] mix_now;
    logic [PIX_W-1:0] mix_result;
    logic [7:0] vbyte;
    logic [3:0] vlen;
    logic vdraw;
    logic last_off;
    logic [3:0] vrem;
    logic [15:0] vnx;
    logic [15:0] vny;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ----------------------------------------
    // Pixel decision
    // ----------------------------------------
    assign read_bit = &(r.src | ~r.rmask[PIX_W-1:0]);
    assign sel_fore = (r.pctl[PCTL_SEL_HI:PCTL_SEL_LO] != SEL_BITMAP) ||
                      r.op_vec || read_bit;
    assign mix_now = sel_fore ? r.fmix : r.bmix;
    assign need_src = (r.fmix[MIX_SRC_HI:MIX_SRC_LO] == SRC_DISPLAY_MEM) ||
                      (r.bmix[MIX_SRC_HI:MIX_SRC_LO] == SRC_DISPLAY_MEM) ||
                      (r.pctl[PCTL_SEL_HI:PCTL_SEL_LO] == SEL_BITMAP);

    pixel_mix_unit #(
        .PIX_W(PIX_W)
    ) u_mix (
        .mix_i(mix_now),
        .fore_colour_i(r.fcol[PIX_W-1:0]),
        .back_colour_i(r.bcol[PIX_W-1:0]),
        .mem_src_i(r.src),
        .dest_i(r.dst),
        .result_o(mix_result)
    );

    // Swap set means the low byte runs first
    assign vbyte = (r.vec_hi == r.cmd[CMD_SWAP_BIT]) ? r.vec[15:8] :
                   r.vec[7:0];
    assign vlen = vbyte[VEC_LEN_HI:VEC_LEN_LO];
    assign vdraw = vbyte[VEC_DRAW_BIT];
    assign last_off = r.cmd[CMD_LAST_OFF_BIT];
    assign vrem = r.vcnt - 4'h1;

    // One 45 degree step; y grows downward
    always_comb
    begin
        vnx = r.dx;
        vny = r.dy;
        case (vbyte[VEC_DIR_HI:VEC_DIR_LO])
            3'h0: vnx = r.dx + 16'h0001;
            3'h1:
            begin
                vnx = r.dx + 16'h0001;
                vny = r.dy - 16'h0001;
            end
            3'h2: vny = r.dy - 16'h0001;
            3'h3:
            begin
                vnx = r.dx - 16'h0001;
                vny = r.dy - 16'h0001;
            end
            3'h4: vnx = r.dx - 16'h0001;
            3'h5:
            begin
                vnx = r.dx - 16'h0001;
                vny = r.dy + 16'h0001;
            end
            3'h6: vny = r.dy + 16'h0001;
            default:
            begin
                vnx = r.dx + 16'h0001;
                vny = r.dy + 16'h0001;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        case (r.st)
            ST_IDLE:
            begin
                if (r.vec_full)
                begin
                    next_r.op_vec = 1'b1;
                    next_r.vec_hi = 1'b0;
                    next_r.dx = r.cur_x;
                    next_r.dy = r.cur_y;
                    next_r.st = ST_VEC;
                end
            end
            ST_SRC:
            begin
                if (!r.req)
                begin
                    next_r.req = 1'b1;
                    next_r.we = 1'b0;
                    if (r.cmd[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_PATTERN_FILL)
                    begin
                        // Tile phase follows destination x and y mod 8
                        next_r.ax = r.cur_x + {13'h0000,
                                    r.dx[2:0] & TILE_MASK};
                        next_r.ay = r.cur_y + {13'h0000,
                                    r.dy[2:0] & TILE_MASK};
                    end
                    else
                    begin
                        next_r.ax = r.sx;
                        next_r.ay = r.sy;
                    end
                end
                else if (mem_ack_i)
                begin
                    next_r.req = 1'b0;
                    next_r.src = mem_rdata_i;
                    next_r.st = ST_DST;
                end
            end
            ST_DST:
            begin
                if (!r.req)
                begin
                    next_r.req = 1'b1;
                    next_r.we = 1'b0;
                    next_r.ax = r.dx;
                    next_r.ay = r.dy;
                end
                else if (mem_ack_i)
                begin
                    next_r.req = 1'b0;
                    next_r.dst = mem_rdata_i;
                    next_r.st = ST_WR;
                end
            end
            ST_WR:
            begin
                if (!r.req)
                begin
                    next_r.req = 1'b1;
                    next_r.we = 1'b1;
                    next_r.wdata = (mix_result & r.wmask[PIX_W-1:0]) |
                                   (r.dst & ~r.wmask[PIX_W-1:0]);
                end
                else if (mem_ack_i)
                begin
                    next_r.req = 1'b0;
                    next_r.we = 1'b0;
                    next_r.st = ST_STEP;
                end
            end
            ST_STEP:
            begin
                if (r.op_vec)
                begin
                    next_r.dx = vnx;
                    next_r.dy = vny;
                    next_r.vcnt = vrem;
                    if (vrem == 4'h0)
                    begin
                        next_r.st = ST_VEC;
                        next_r.vec_hi = 1'b1;
                        if (r.vec_hi)
                        begin
                            next_r.st = ST_IDLE;
                            next_r.op_vec = 1'b0;
                            next_r.vec_full = 1'b0;
                            next_r.cur_x = vnx;
                            next_r.cur_y = vny;
                        end
                    end
                    else if (vdraw && !(vrem == 4'h1 && last_off))
                        next_r.st = ST_DST;
                end
                else if (r.xcnt == r.size_w)
                begin
                    next_r.xcnt = 16'h0000;
                    next_r.sx = r.cur_x;
                    next_r.dx = r.stp_x;
                    if (r.ycnt == r.size_h)
                        next_r.st = ST_IDLE;
                    else
                    begin
                        next_r.ycnt = r.ycnt + 16'h0001;
                        next_r.sy = r.cmd[CMD_Y_POS_BIT] ?
                                    r.sy + 16'h0001 : r.sy - 16'h0001;
                        next_r.dy = r.cmd[CMD_Y_POS_BIT] ?
                                    r.dy + 16'h0001 : r.dy - 16'h0001;
                        next_r.st = need_src ? ST_SRC : ST_DST;
                    end
                end
                else
                begin
                    next_r.xcnt = r.xcnt + 16'h0001;
                    next_r.sx = r.cmd[CMD_X_POS_BIT] ?
                                r.sx + 16'h0001 : r.sx - 16'h0001;
                    next_r.dx = r.cmd[CMD_X_POS_BIT] ?
                                r.dx + 16'h0001 : r.dx - 16'h0001;
                    next_r.st = need_src ? ST_SRC : ST_DST;
                end
            end
            ST_VEC:
            begin
                next_r.vcnt = vlen;
                if (vlen == 4'h0)
                begin
                    next_r.vec_hi = 1'b1;
                    if (r.vec_hi)
                    begin
                        next_r.st = ST_IDLE;
                        next_r.op_vec = 1'b0;
                        next_r.vec_full = 1'b0;
                        next_r.cur_x = r.dx;
                        next_r.cur_y = r.dy;
                    end
                end
                else if (vdraw && !(vlen == 4'h1 && last_off))
                    next_r.st = ST_DST;
                else
                    next_r.st = ST_STEP;
            end
            default:
                next_r.st = ST_IDLE;
        endcase

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                OFF_COMMAND:
                begin
                    if (r.st == ST_IDLE && !r.vec_full)
                    begin
                        next_r.cmd = reg_wdata_i[15:0];
                        next_r.sx = r.cur_x;
                        next_r.sy = r.cur_y;
                        next_r.dx = r.stp_x;
                        next_r.dy = r.stp_y;
                        next_r.xcnt = 16'h0000;
                        next_r.ycnt = 16'h0000;
                        next_r.op_vec = 1'b0;
                        if (reg_wdata_i[CMD_DRAW_BIT] &&
                            (reg_wdata_i[CMD_TYPE_HI:CMD_TYPE_LO] ==
                             TYPE_RECT_COPY ||
                             reg_wdata_i[CMD_TYPE_HI:CMD_TYPE_LO] ==
                             TYPE_PATTERN_FILL))
                            next_r.st = need_src ? ST_SRC : ST_DST;
                    end
                end
                OFF_SHORT_VECTOR:
                begin
                    // A slot freed this same cycle still takes the word
                    if (!next_r.vec_full)
                    begin
                        next_r.vec = reg_wdata_i[15:0];
                        next_r.vec_full = 1'b1;
                    end
                end
                OFF_WRITE_MASK: next_r.wmask = reg_wdata_i;
                OFF_READ_MASK: next_r.rmask = reg_wdata_i;
                OFF_PIXEL_CONTROL: next_r.pctl = reg_wdata_i[15:0];
                OFF_CURRENT_POINT:
                begin
                    next_r.cur_x = reg_wdata_i[31:16];
                    next_r.cur_y = reg_wdata_i[15:0];
                end
                OFF_DEST_POINT:
                begin
                    next_r.stp_x = reg_wdata_i[31:16];
                    next_r.stp_y = reg_wdata_i[15:0];
                end
                OFF_RECT_SIZE:
                begin
                    next_r.size_w = reg_wdata_i[31:16];
                    next_r.size_h = reg_wdata_i[15:0];
                end
                OFF_MIX_PAIR:
                begin
                    next_r.fmix = reg_wdata_i[31:16];
                    next_r.bmix = reg_wdata_i[15:0];
                end
                OFF_FORE_COLOUR: next_r.fcol = reg_wdata_i;
                OFF_BACK_COLOUR: next_r.bcol = reg_wdata_i;
                default: ;
            endcase
        end

        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        if (reg_rd_i)
        begin
            next_r.rdata = 32'h00000000;
            case (reg_addr_i)
                OFF_COMMAND:
                begin
                    next_r.rdata[STAT_BUSY_BIT] = (r.st != ST_IDLE);
                    next_r.rdata[STAT_VEC_FULL_BIT] = r.vec_full;
                end
                OFF_WRITE_MASK: next_r.rdata = r.wmask;
                OFF_READ_MASK: next_r.rdata = r.rmask;
                OFF_PIXEL_CONTROL: next_r.rdata = {16'h0000, r.pctl};
                OFF_CURRENT_POINT: next_r.rdata = {r.cur_x, r.cur_y};
                OFF_DEST_POINT: next_r.rdata = {r.stp_x, r.stp_y};
                OFF_RECT_SIZE: next_r.rdata = {r.size_w, r.size_h};
                OFF_MIX_PAIR: next_r.rdata = {r.fmix, r.bmix};
                OFF_FORE_COLOUR: next_r.rdata = r.fcol;
                OFF_BACK_COLOUR: next_r.rdata = r.bcol;
                default: next_r.rdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.cmd <= RST_COMMAND;
            r.pctl <= RST_PIXEL_CONTROL;
            r.wmask <= RST_MASK;
            r.rmask <= RST_MASK;
        end
        else
            r <= next_r;
    end

    assign reg_rdata_o = r.rdata;
    assign busy_o = (r.st != ST_IDLE) || r.vec_full;
    assign mem_req_o = r.req;
    assign mem_we_o = r.we;
    assign mem_x_o = r.ax;
    assign mem_y_o = r.ay;
    assign mem_wdata_o = r.wdata;
    assign mem_plane_mask_o = r.wmask;
endmodule // blit_pattern_stroke_engine

// file: src/blit_engine_pkg.sv
// Overview of operation
// - Rectangle copy moves a display area elsewhere
// - Source, destination, size come from registers
// - Mix 0067H copies memory value unchanged
// - Read bit is AND of enabled planes
// - Read bit picks foreground or background mix
// - Only write-mask planes of destination change
// - Colour mixes expand mono to two colours
// - Pattern tiles 8x8, aligned to multiples of 8
// - Pattern fill type code starts pattern fill
// - Write mask holds until software rewrites it
// - Short vectors: up to 15 pixels, 8 directions
// - Vector byte: direction, draw flag, length
// - Two vectors per word, swap orders them
// - Parameter-only command latches, writes no pixel
// - Last-pixel-off omits each vector's final pixel
package blit_engine_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [15:0] OFF_COMMAND = 16'h9AE8;
    localparam logic [15:0] OFF_SHORT_VECTOR = 16'h9EE8;
    localparam logic [15:0] OFF_WRITE_MASK = 16'hAAE8;
    localparam logic [15:0] OFF_READ_MASK = 16'hAEE8;
    localparam logic [15:0] OFF_PIXEL_CONTROL = 16'hBEE8;
    localparam logic [15:0] OFF_CURRENT_POINT = 16'h8200;
    localparam logic [15:0] OFF_DEST_POINT = 16'h8204;
    localparam logic [15:0] OFF_RECT_SIZE = 16'h8208;
    localparam logic [15:0] OFF_MIX_PAIR = 16'h820C;
    localparam logic [15:0] OFF_FORE_COLOUR = 16'h8210;
    localparam logic [15:0] OFF_BACK_COLOUR = 16'h8214;

    // ----------------------------------------
    // Command and status fields
    // ----------------------------------------
    localparam int CMD_TYPE_HI = 15;
    localparam int CMD_TYPE_LO = 13;
    localparam int CMD_SWAP_BIT = 12;
    localparam int CMD_Y_POS_BIT = 7;
    localparam int CMD_X_MAJOR_BIT = 6;
    localparam int CMD_X_POS_BIT = 5;
    localparam int CMD_DRAW_BIT = 4;
    localparam int CMD_LAST_OFF_BIT = 2;
    localparam int CMD_MULTI_BIT = 1;
    localparam logic [2:0] TYPE_PARAM_ONLY = 3'h0;
    localparam logic [2:0] TYPE_RECT_COPY = 3'h6;
    localparam logic [2:0] TYPE_PATTERN_FILL = 3'h7;
    localparam int STAT_BUSY_BIT = 9;
    localparam int STAT_VEC_FULL_BIT = 0;

    // ----------------------------------------
    // Mix, pixel control and vector fields
    // ----------------------------------------
    localparam int MIX_SRC_HI = 6;
    localparam int MIX_SRC_LO = 5;
    localparam logic [1:0] SRC_BACK_COLOUR = 2'h0;
    localparam logic [1:0] SRC_FORE_COLOUR = 2'h1;
    localparam logic [1:0] SRC_HOST_DATA = 2'h2;
    localparam logic [1:0] SRC_DISPLAY_MEM = 2'h3;
    localparam int PCTL_SEL_HI = 7;
    localparam int PCTL_SEL_LO = 6;
    localparam logic [1:0] SEL_BITMAP = 2'h3;
    localparam int VEC_DIR_HI = 7;
    localparam int VEC_DIR_LO = 5;
    localparam int VEC_DRAW_BIT = 4;
    localparam int VEC_LEN_HI = 3;
    localparam int VEC_LEN_LO = 0;
    localparam logic [2:0] TILE_MASK = 3'h7;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] RST_COMMAND = 16'h0000;
    localparam logic [15:0] RST_PIXEL_CONTROL = 16'hA000;
    localparam logic [31:0] RST_MASK = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SRC,
        ST_DST,
        ST_WR,
        ST_STEP,
        ST_VEC
    } engine_state_t;

endpackage

// file: src/pixel_mix_unit.sv
`timescale 1ns/1ps
module pixel_mix_unit
    import blit_engine_pkg::*;
#(
    parameter int PIX_W = 32
)
(
    input wire logic [15:0] mix_i,
    input wire logic [PIX_W-1:0] fore_colour_i,
    input wire logic [PIX_W-1:0] back_colour_i,
    input wire logic [PIX_W-1:0] mem_src_i,
    input wire logic [PIX_W-1:0] dest_i,
    output logic [PIX_W-1:0] result_o
);
    logic [PIX_W-1:0] s;
    logic [PIX_W-1:0] d;

    // ----------------------------------------
    // Colour source and raster function
    // ----------------------------------------
    always_comb
    begin
        case (mix_i[MIX_SRC_HI:MIX_SRC_LO])
            SRC_BACK_COLOUR: s = back_colour_i;
            SRC_FORE_COLOUR: s = fore_colour_i;
            SRC_DISPLAY_MEM: s = mem_src_i;
            default: s = '0;
        endcase
        d = dest_i;
        case (mix_i[3:0])
            4'h0: result_o = ~d;
            4'h1: result_o = '0;
            4'h2: result_o = '1;
            4'h3: result_o = d;
            4'h4: result_o = ~s;
            4'h5: result_o = s ^ d;
            4'h6: result_o = ~(s ^ d);
            4'h7: result_o = s;
            4'h8: result_o = ~s | ~d;
            4'h9: result_o = ~s | d;
            4'hA: result_o = s | ~d;
            4'hB: result_o = s | d;
            4'hC: result_o = s & d;
            4'hD: result_o = ~s & d;
            4'hE: result_o = s & ~d;
            default: result_o = ~s & ~d;
        endcase
    end
endmodule // pixel_mix_unit

// file: verif/disp_mem_model.sv
`timescale 1ns/1ps
module disp_mem_model
#(
    parameter int PIX_W = 32
)
(
    input wire logic clk_i,
    input wire logic [3:0] dly_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] x_i,
    input wire logic [15:0] y_i,
    input wire logic [PIX_W-1:0] wdata_i,
    output logic ack_o,
    output logic [PIX_W-1:0] rdata_o
);
    logic [PIX_W-1:0] mem [256];
    logic [3:0] cnt;
    logic [7:0] idx;
    assign idx = {y_i[3:0], x_i[3:0]};
    // Inverted off the ack so a stale sample never matches
    assign rdata_o = ack_o ? mem[idx] : ~mem[idx];
    initial
    begin
        ack_o = 1'b0;
        cnt = 4'h0;
        for (int i = 0; i < 256; i++)
            mem[i] = PIX_W'(32'h5A5A5A00 | i);
    end
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        if (req_i && !ack_o)
        begin
            if (cnt == dly_i)
            begin
                ack_o <= 1'b1;
                cnt <= 4'h0;
                if (we_i)
                    mem[idx] <= wdata_i;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule // disp_mem_model

// file: verif/blit_engine_properties.sv
`timescale 1ns/1ps
module blit_engine_properties
    import blit_engine_pkg::*;
#(
    parameter int PIX_W = 32
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic busy_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [15:0] mem_x_o,
    input wire logic [15:0] mem_y_o,
    input wire logic [PIX_W-1:0] mem_wdata_o,
    input wire logic [31:0] mem_plane_mask_o,
    input wire logic mem_ack_i
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic cmd_wr;
    logic mask_wr;
    assign cmd_wr = reg_wr_i && reg_addr_i == OFF_COMMAND && !busy_o;
    assign mask_wr = reg_wr_i && reg_addr_i == OFF_WRITE_MASK;
    sequence s_wait;
        mem_req_o && !mem_ack_i;
    endsequence
    sequence s_done;
        mem_req_o && mem_ack_i;
    endsequence
    AST_REQ_HOLD:
    assert property (s_wait |=> mem_req_o && $stable(mem_x_o)
        && $stable(mem_y_o) && $stable(mem_wdata_o) && $stable(mem_we_o))
        else $error("memory request changed before ack");
    AST_REQ_GAP:
    assert property (s_done |=> !mem_req_o)
        else $error("no idle cycle after ack");
    AST_BUSY_REQ:
    assert property (mem_req_o |-> busy_o)
        else $error("memory access while not busy");
    AST_CMD_BUSY:
    assert property (cmd_wr && reg_wdata_i[15:13] == TYPE_RECT_COPY
        && reg_wdata_i[4] |=> busy_o [*2])
        else $error("copy command did not start");
    AST_MASK_FOLLOW:
    assert property (mask_wr |=> mem_plane_mask_o == $past(reg_wdata_i))
        else $error("plane mask not taken");
    AST_MASK_HOLD:
    assert property (!mask_wr |=> $stable(mem_plane_mask_o))
        else $error("plane mask changed unwritten");
    AST_PARAM_QUIET:
    assert property (cmd_wr && reg_wdata_i[15:13] == TYPE_PARAM_ONLY
        |=> !(mem_req_o && mem_we_o) [*4])
        else $error("parameter command wrote a pixel");
    AST_UNMAPPED:
    assert property (reg_rd_i && reg_addr_i == 16'h0010
        |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // blit_engine_properties

bind blit_pattern_stroke_engine blit_engine_properties #(.PIX_W(PIX_W))
    blit_engine_properties_i (.ref_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .busy_o, .mem_req_o,
    .mem_we_o, .mem_x_o, .mem_y_o, .mem_wdata_o, .mem_plane_mask_o,
    .mem_ack_i);

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import blit_engine_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o, mem_wdata_o, mem_plane_mask_o, mem_rdata_i;
    logic busy_o, mem_req_o, mem_we_o, mem_ack_i;
    logic [15:0] mem_x_o, mem_y_o;
    logic [3:0] dly = 4'h0;
    int mismatches = 0;
    int checked = 0;
    int writes = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    blit_pattern_stroke_engine blit_pattern_stroke_engine_i (.ref_clk_i,
        .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
        .reg_rdata_o, .busy_o, .mem_req_o, .mem_we_o, .mem_x_o, .mem_y_o,
        .mem_wdata_o, .mem_plane_mask_o, .mem_ack_i, .mem_rdata_i);
    disp_mem_model disp_mem_model_i (.clk_i(ref_clk_i), .dly_i(dly),
        .req_i(mem_req_o), .we_i(mem_we_o), .x_i(mem_x_o), .y_i(mem_y_o),
        .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    always @(posedge ref_clk_i)
        if (mem_req_o && mem_we_o && mem_ack_i)
            writes++;
    // ------
    // Tasks
    // ------
    function automatic logic [31:0] px(int x, int y);
        return disp_mem_model_i.mem[y * 16 + x];
    endfunction
    function automatic logic [31:0] src(int x, int y);
        return 32'h5A5A5A00 | (y * 16 + x);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge ref_clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge ref_clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_o;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (busy_o !== 1'b0 && n < 500)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        check(32'(n < 500), 32'h1);
    endtask
    // Coordinates, size and mixes go in ahead of the command
    task automatic blit(input logic [31:0] c, dp, sz, mx, cmd);
        wr(OFF_CURRENT_POINT, c);
        wr(OFF_DEST_POINT, dp);
        wr(OFF_RECT_SIZE, sz);
        wr(OFF_MIX_PAIR, mx);
        wr(OFF_COMMAND, cmd);
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
    // ------
    // Tests
    // ------
    initial
    begin
        logic [31:0] d;
        int w0;
        repeat (6) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        rd(OFF_PIXEL_CONTROL, d);
        check(d, 32'h0000A000);
        rd(16'h0010, d);
        check(d, 32'h0);
        dly = 4'h3;
        blit(32'h0, 32'h00040000, 32'h00010000, 32'h00670000, 32'hC0F1);
        rd(OFF_COMMAND, d);
        check(32'(d[STAT_BUSY_BIT]), 32'h1);
        wait_idle();
        check(px(4, 0), src(0, 0));
        check(px(5, 0), src(1, 0));
        check(px(6, 0), src(6, 0));
        dly = 4'h0;
        wr(OFF_READ_MASK, 32'h3);
        wr(OFF_WRITE_MASK, 32'h4);
        wr(OFF_PIXEL_CONTROL, 32'hA0C0);
        blit(32'h00020001, 32'h00070001, 32'h00010000, 32'h00020001,
            32'hC0F3);
        wait_idle();
        check(px(7, 1), src(7, 1) & ~32'h4);
        check(px(8, 1), src(8, 1) | 32'h4);
        check(mem_plane_mask_o, 32'h4);
        rd(OFF_WRITE_MASK, d);
        check(d, 32'h4);
        wr(OFF_WRITE_MASK, 32'hFFFFFFFF);
        wr(OFF_READ_MASK, 32'h1);
        wr(OFF_FORE_COLOUR, 32'h4);
        wr(OFF_BACK_COLOUR, 32'h1);
        // Negative X from the far edges
        blit(32'h00010002, 32'h00090002, 32'h00010000, 32'h00270007,
            32'hC0D3);
        wait_idle();
        check(px(8, 2), 32'h1);
        check(px(9, 2), 32'h4);
        wr(OFF_PIXEL_CONTROL, 32'hA000);
        blit(32'h3, 32'h00090004, 32'h00010000, 32'h00670000, 32'hE0F1);
        wait_idle();
        check(px(9, 4), src(1, 7));
        check(px(10, 4), src(2, 7));
        check(px(8, 4), src(8, 4));
        w0 = writes;
        wr(OFF_FORE_COLOUR, 32'h7);
        wr(OFF_MIX_PAIR, 32'h00270000);
        wr(OFF_CURRENT_POINT, 32'h0002000A);
        wr(OFF_COMMAND, 32'h1016);
        wait_idle();
        check(writes - w0, 32'h0);
        wr(OFF_SHORT_VECTOR, 32'hD213);
        wait_idle();
        check(writes - w0, 32'h3);
        check(px(2, 10), 32'h7);
        check(px(3, 10), 32'h7);
        check(px(4, 10), src(4, 10));
        check(px(5, 10), 32'h7);
        check(px(5, 11), src(5, 11));
        wrap_up();
    end
endmodule // tb_top
